// File: include/rcs_pkg.sv
// Constants and carrier types for the program memory protection block.
// Functional notes
// - With no security bit set and no key programmed, verify reads return the stored code bytes.
// - Once a key byte other than all ones is programmed, verify reads return encrypted data unless the second bit is set.
// - Encrypted verify byte is stored byte XNOR one key byte.
// - First bit set: table reads run from external memory cannot fetch internal code.
// - First bit set: external access pin is latched at reset and held.
// - First bit set: further programming of code and key is refused.
// - Second bit set: all verify reads of user code are blocked.
// - Key array holds 64 bytes that read as all ones until programmed.
package rcs_pkg;
	localparam int RCS_CODE_BYTES = 4096;
	localparam int RCS_KEY_BYTES = 64;
	localparam logic [12:0] RCS_CODE_LAST = 13'h0FFF;
	localparam logic [12:0] RCS_KEY_BASE = 13'h1000;
	localparam logic [12:0] RCS_KEY_LAST = 13'h103F;
	localparam logic [12:0] RCS_OPT_ADDR = 13'h1040;
	localparam int RCS_OPT_FIRST_POS = 0;
	localparam int RCS_OPT_SECOND_POS = 1;
	localparam logic [7:0] RCS_KEY_ERASED = 8'hFF;
	localparam logic [7:0] RCS_BLOCKED_DATA = 8'h00;
	localparam logic [1:0] RCS_OPT_RESET = 2'h0;

	// Request from the CPU fetch path.
	typedef struct packed {
		logic valid;
		logic table_read;
		logic from_external;
		logic [11:0] addr;
	} rcs_fetch_s;

	// Verify request from the external verifier.
	typedef struct packed {
		logic valid;
		logic [11:0] addr;
	} rcs_verify_s;

	// One image byte to load.
	typedef struct packed {
		logic valid;
		logic [12:0] addr;
		logic [7:0] data;
	} rcs_prog_s;

	// Answer to a fetch or a verify read.
	typedef struct packed {
		logic valid;
		logic blocked;
		logic [7:0] data;
	} rcs_resp_s;

	// All registered state of the block apart from the image arrays.
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic pin_latched;
		logic latch_pending;
		logic [1:0] opt;
		logic [63:0] key_written;
		logic key_prog;
		logic prog_refused;
		rcs_resp_s fetch_resp;
		rcs_resp_s verify_resp;
	} rcs_state_s;
endpackage : rcs_pkg

// File: rtl/rcs_protect.sv
// Program memory protection: image load, guarded fetch, encrypted verify.
`timescale 1ns/1ns
module rcs_protect (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// External access pin, asynchronous.
	input wire logic external_access_pin,
	// Image load port.
	input wire rcs_pkg::rcs_prog_s prog_req,
	output logic prog_refused,
	// CPU fetch path.
	input wire rcs_pkg::rcs_fetch_s fetch_req,
	output rcs_pkg::rcs_resp_s fetch_resp,
	// Verify port.
	input wire rcs_pkg::rcs_verify_s verify_req,
	output rcs_pkg::rcs_resp_s verify_resp,
	// Status.
	output logic ext_access_level,
	output logic secure_bit_first,
	output logic secure_bit_second,
	output logic key_programmed
);
	rcs_pkg::rcs_state_s st_ff;
	rcs_pkg::rcs_state_s nxt_st;
	logic [7:0] code_mem [rcs_pkg::RCS_CODE_BYTES];
	logic [7:0] key_mem [rcs_pkg::RCS_KEY_BYTES];
	logic in_code;
	logic in_key;
	logic in_opt;
	logic code_we;
	logic key_we;
	logic fetch_block;
	logic [7:0] plain_rd;
	logic [7:0] key_rd;
	logic [7:0] fetch_rd;

	// Address decode of the image load port.
	assign in_code = prog_req.addr <= rcs_pkg::RCS_CODE_LAST;
	assign in_key = (prog_req.addr >= rcs_pkg::RCS_KEY_BASE) &&
		(prog_req.addr <= rcs_pkg::RCS_KEY_LAST);
	assign in_opt = prog_req.addr == rcs_pkg::RCS_OPT_ADDR;
	assign code_we = prog_req.valid && in_code && !st_ff.opt[rcs_pkg::RCS_OPT_FIRST_POS];
	assign key_we = prog_req.valid && in_key && !st_ff.opt[rcs_pkg::RCS_OPT_FIRST_POS];

	// Array reads for verify and fetch.
	assign plain_rd = code_mem[verify_req.addr];
	assign fetch_rd = code_mem[fetch_req.addr];
	assign key_rd = st_ff.key_written[verify_req.addr[5:0]] ?
		key_mem[verify_req.addr[5:0]] : rcs_pkg::RCS_KEY_ERASED;
	assign fetch_block = st_ff.opt[rcs_pkg::RCS_OPT_FIRST_POS] && fetch_req.table_read &&
		fetch_req.from_external;

	// Next state; reset is synchronous and leaves the pin synchroniser running.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pin_meta = external_access_pin;
		nxt_st.pin_sync = st_ff.pin_meta;
		if (st_ff.latch_pending) begin
			nxt_st.pin_latched = st_ff.pin_sync;
			nxt_st.latch_pending = 1'b0;
		end
		nxt_st.prog_refused = prog_req.valid &&
			((!in_code && !in_key && !in_opt) ||
			((in_code || in_key) && st_ff.opt[rcs_pkg::RCS_OPT_FIRST_POS]));
		// Security bits only ever get set; the other bit stays programmable.
		if (prog_req.valid && in_opt) begin
			nxt_st.opt = st_ff.opt | prog_req.data[1:0];
		end
		if (key_we) begin
			nxt_st.key_written[prog_req.addr[5:0]] = 1'b1;
			if (prog_req.data != rcs_pkg::RCS_KEY_ERASED) begin
				nxt_st.key_prog = 1'b1;
			end
		end
		nxt_st.fetch_resp.valid = fetch_req.valid;
		nxt_st.fetch_resp.blocked = fetch_req.valid && fetch_block;
		nxt_st.fetch_resp.data = fetch_block ? rcs_pkg::RCS_BLOCKED_DATA : fetch_rd;
		nxt_st.verify_resp.valid = verify_req.valid;
		nxt_st.verify_resp.blocked = verify_req.valid && st_ff.opt[rcs_pkg::RCS_OPT_SECOND_POS];
		if (st_ff.opt[rcs_pkg::RCS_OPT_SECOND_POS]) begin
			nxt_st.verify_resp.data = rcs_pkg::RCS_BLOCKED_DATA;
		end else if (st_ff.key_prog) begin
			nxt_st.verify_resp.data = ~(plain_rd ^ key_rd);
		end else begin
			nxt_st.verify_resp.data = plain_rd;
		end
		if (rst) begin
			nxt_st = '0;
			nxt_st.pin_meta = external_access_pin;
			nxt_st.pin_sync = st_ff.pin_meta;
			nxt_st.latch_pending = 1'b1;
			nxt_st.opt = rcs_pkg::RCS_OPT_RESET;
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		st_ff <= nxt_st;
	end

	// Image arrays; contents are not touched by reset.
	always_ff @(posedge clock) begin
		if (code_we) begin
			code_mem[prog_req.addr[11:0]] <= prog_req.data;
		end
		if (key_we) begin
			key_mem[prog_req.addr[5:0]] <= prog_req.data;
		end
	end

	// Outputs.
	assign prog_refused = st_ff.prog_refused;
	assign fetch_resp = st_ff.fetch_resp;
	assign verify_resp = st_ff.verify_resp;
	assign secure_bit_first = st_ff.opt[rcs_pkg::RCS_OPT_FIRST_POS];
	assign secure_bit_second = st_ff.opt[rcs_pkg::RCS_OPT_SECOND_POS];
	assign key_programmed = st_ff.key_prog;
	assign ext_access_level = secure_bit_first ? st_ff.pin_latched : st_ff.pin_sync;

	// Assertions share the system clock and rest while reset is high.
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);

	// A secured table read from outside gets the blocked answer.
	fetch_block_a: assert property (fetch_req.valid && fetch_block |=>
		fetch_resp.blocked && fetch_resp.data == rcs_pkg::RCS_BLOCKED_DATA)
		else $error("Secured external table read was not blocked.");
	// Every fetch request gets its answer on the next cycle.
	fetch_valid_a: assert property (fetch_req.valid |=> fetch_resp.valid)
		else $error("Fetch answer missing.");
	// Without the first bit no fetch is ever blocked.
	fetch_open_a: assert property (fetch_req.valid && !secure_bit_first |=>
		!fetch_resp.blocked)
		else $error("Fetch blocked while unsecured.");
	// Internal fetches return the stored byte.
	fetch_pass_a: assert property (fetch_req.valid && !fetch_req.from_external |=>
		!fetch_resp.blocked && fetch_resp.data == $past(fetch_rd))
		else $error("Internal fetch returned wrong data.");
	// Open verify with no key returns the stored byte.
	verify_plain_a: assert property (verify_req.valid && !secure_bit_second &&
		!key_programmed |=> !verify_resp.blocked && verify_resp.data == $past(plain_rd))
		else $error("Plain verify byte differs from stored byte.");
	// Every verify request gets its answer on the next cycle.
	verify_valid_a: assert property (verify_req.valid |=> verify_resp.valid)
		else $error("Verify answer missing.");
	// Without the second bit verify is never blocked.
	verify_open_a: assert property (verify_req.valid && !secure_bit_second |=>
		!verify_resp.blocked)
		else $error("Verify blocked while unsecured.");
	// A programmed key changes the byte unless its key byte is erased.
	verify_crypt_a: assert property (verify_req.valid && !secure_bit_second &&
		key_programmed |=> verify_resp.data != $past(plain_rd) || $past(key_rd) == 8'hFF)
		else $error("Verify byte was not encrypted.");
	// A key write other than all ones raises the key flag.
	key_flag_a: assert property (key_we && prog_req.data != rcs_pkg::RCS_KEY_ERASED |=>
		key_programmed)
		else $error("Key write did not set the key flag.");
	// The encrypted byte is the XNOR of stored byte and key byte.
	verify_xnor_a: assert property (verify_req.valid && !secure_bit_second &&
		key_programmed |=> verify_resp.data == ~($past(plain_rd) ^ $past(key_rd)))
		else $error("Encrypted verify byte is not the XNOR.");
	// A written key byte is picked by the low six address bits.
	key_select_a: assert property (verify_req.valid && !secure_bit_second &&
		key_programmed && st_ff.key_written[verify_req.addr[5:0]] |=>
		verify_resp.data == ~($past(plain_rd) ^ $past(key_mem[verify_req.addr[5:0]])))
		else $error("Key byte not chosen by low address bits.");
	// An unwritten key byte reads as ones, so the byte comes back plain.
	key_erased_a: assert property (verify_req.valid && !secure_bit_second &&
		key_programmed && !st_ff.key_written[verify_req.addr[5:0]] |=>
		verify_resp.data == $past(plain_rd))
		else $error("Unprogrammed key byte not all ones.");
	// The pin is taken from the synchroniser on the edge after reset.
	pin_latch_a: assert property (st_ff.latch_pending |=>
		st_ff.pin_latched == $past(st_ff.pin_sync))
		else $error("External access level not latched after reset.");
	// Once secured, the latched level does not move.
	pin_hold_a: assert property (secure_bit_first && !st_ff.latch_pending |=>
		ext_access_level == $past(ext_access_level))
		else $error("Latched external access level changed.");
	// Unsecured, the level follows the pin two flops late.
	pin_live_a: assert property (!secure_bit_first ##1 !secure_bit_first |->
		ext_access_level == $past(st_ff.pin_meta))
		else $error("External access level does not follow the pin.");
	// Code and key are locked once the first bit is set.
	prog_lock_a: assert property (prog_req.valid && secure_bit_first &&
		(in_code || in_key) |=> prog_refused)
		else $error("Programming accepted after lock.");
	// Before the lock, code and key bytes are taken.
	prog_accept_a: assert property (prog_req.valid && !secure_bit_first &&
		(in_code || in_key) |=> !prog_refused)
		else $error("Programming refused before lock.");
	// The first bit stays set until reset.
	first_hold_a: assert property (secure_bit_first |=> secure_bit_first)
		else $error("First security bit cleared.");
	// Verify answers are blocked once the second bit is set.
	verify_deny_a: assert property (verify_req.valid && secure_bit_second |=>
		verify_resp.blocked && verify_resp.data == rcs_pkg::RCS_BLOCKED_DATA)
		else $error("Verify read not blocked.");
	// The second bit stays set until reset.
	second_hold_a: assert property (secure_bit_second |=> secure_bit_second)
		else $error("Second security bit cleared.");

	// Main scenarios reached by the tests.
	cover_crypt_c: cover property (verify_resp.valid && key_programmed && !secure_bit_second);
	cover_block_c: cover property (fetch_resp.blocked);
	cover_deny_c: cover property (verify_resp.blocked);
	cover_refuse_c: cover property (prog_refused && secure_bit_first);
	cover_latch_c: cover property (secure_bit_first && ext_access_level);
endmodule : rcs_protect

// File: test/rcs_image_src.sv
// Image supplier model that loads the code image one byte per request.
`timescale 1ns/1ns
module rcs_image_src (
	// Clock.
	input wire logic clock,
	// Image load port.
	output rcs_pkg::rcs_prog_s prog_req
);
	// The load port is all low at time zero.
	initial prog_req = '0;
	task automatic put(input logic [12:0] a, input logic [7:0] d);
		@(negedge clock);
		prog_req = '{1'b1, a, (a == rcs_pkg::RCS_OPT_ADDR && d[1]) ? (d | 8'h01) : d};
		@(negedge clock);
		prog_req = '{1'b0, ~a, ~d}; // Released lines carry stale inverted values.
	endtask : put
endmodule : rcs_image_src

// File: test/tb_rom_code_security_encryption.sv
// Self-checking bench for the program memory protection block.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_rom_code_security_encryption;
	logic clock, rst, pin, prog_refused, acc_level, first_bit, second_bit, key_prog, mkey;
	logic [1:0] mopt;
	logic [8:0] e9;
	rcs_pkg::rcs_prog_s prog_req;
	rcs_pkg::rcs_fetch_s fetch_req;
	rcs_pkg::rcs_verify_s verify_req;
	rcs_pkg::rcs_resp_s fetch_resp, verify_resp;
	logic [7:0] code [0:4095];
	logic [7:0] key [0:63];
	logic [8:0] fq[$], vq[$];
	logic [11:0] addrs [5] = '{12'h000, 12'h001, 12'h03F, 12'h040, 12'hFFF};
	logic [31:0] seed = 32'h00000062;
	int n_errors = 0;
	int checked = 0;
	rcs_image_src src (.clock(clock), .prog_req(prog_req));
	rcs_protect uut (.clock(clock), .rst(rst), .external_access_pin(pin), .prog_req(prog_req),
		.prog_refused(prog_refused), .fetch_req(fetch_req), .fetch_resp(fetch_resp),
		.verify_req(verify_req), .verify_resp(verify_resp), .ext_access_level(acc_level),
		.secure_bit_first(first_bit), .secure_bit_second(second_bit), .key_programmed(key_prog));
	// Xorshift source of random image bytes.
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// Loads one byte, checks the refusal pulse and updates the reference image.
	task automatic load(input logic [12:0] a, input logic [7:0] d, input logic refuse);
		logic kin;
		kin = a >= rcs_pkg::RCS_KEY_BASE && a <= rcs_pkg::RCS_KEY_LAST;
		src.put(a, d);
		`CHK(prog_refused, refuse)
		if (!refuse && a <= rcs_pkg::RCS_CODE_LAST) code[a[11:0]] = d;
		if (!refuse && kin) key[a[5:0]] = d;
		if (!refuse && kin && d != 8'hFF) mkey = 1'b1;
		if (a == rcs_pkg::RCS_OPT_ADDR) mopt = mopt | d[1:0];
	endtask : load
	task automatic rd(input logic ver, input logic tr, input logic ext, input logic [11:0] a);
		@(negedge clock);
		if (ver) begin
			verify_req = '{1'b1, a};
			vq.push_back(mopt[1] ? 9'h100 : {1'b0, mkey ? ~(code[a] ^ key[a[5:0]]) : code[a]});
		end else begin
			fetch_req = '{1'b1, tr, ext, a};
			fq.push_back((tr & ext & mopt[0]) ? 9'h100 : {1'b0, code[a]});
		end
		@(negedge clock);
		verify_req.valid = 1'b0;
		fetch_req.valid = 1'b0;
	endtask : rd
	// Watches both answer ports and compares each answer with the oldest note.
	always @(negedge clock) begin
		if (fetch_resp.valid === 1'b1) begin
			e9 = fq.pop_front();
			`CHK({fetch_resp.blocked, fetch_resp.data}, e9)
		end
		if (verify_resp.valid === 1'b1) begin
			e9 = vq.pop_front();
			`CHK({verify_resp.blocked, verify_resp.data}, e9)
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Watchdog well beyond the roughly 130 cycles the tests need.
	initial begin
		#40000;
		n_errors++;
		summarize();
	end
	// Resets the block with the pin at the given level and clears the reference key, key flag and option bits.
	task automatic do_reset(input logic p);
		rst = 1'b1;
		pin = p;
		mopt = 2'h0;
		mkey = 1'b0;
		foreach (key[i]) key[i] = 8'hFF;
		repeat (6) @(negedge clock);
		rst = 1'b0;
	endtask : do_reset
	initial begin
		fetch_req = '0;
		verify_req = '0;
		do_reset(1'b0);
		foreach (addrs[i]) load({1'b0, addrs[i]}, rnd(), 1'b0);
		foreach (addrs[i]) rd(1'b1, 1'b0, 1'b0, addrs[i]);
		pin = 1'b1;
		repeat (4) @(negedge clock);
		`CHK(acc_level, 1'b1)
		$display("plain verify done");
		load(13'h1000, rnd() & 8'hFE, 1'b0);
		load(13'h103F, rnd() & 8'hFE, 1'b0);
		`CHK(key_prog, 1'b1)
		foreach (addrs[i]) rd(1'b1, 1'b0, 1'b0, addrs[i]);
		foreach (addrs[i]) rd(1'b0, 1'b1, 1'b1, addrs[i]);
		$display("encrypted verify done");
		load(13'h1040, 8'h01, 1'b0);
		`CHK(first_bit, 1'b1)
		`CHK(acc_level, 1'b0)
		load(13'h0000, rnd(), 1'b1);
		load(13'h1001, 8'h00, 1'b1);
		load(13'h1041, 8'h00, 1'b1);
		foreach (addrs[i]) begin
			rd(1'b0, 1'b1, 1'b1, addrs[i]);
			rd(1'b0, 1'b1, 1'b0, addrs[i]);
			rd(1'b0, 1'b0, 1'b1, addrs[i]);
			rd(1'b1, 1'b0, 1'b0, addrs[i]);
		end
		$display("first bit done");
		do_reset(1'b1);
		// second bit only with the first
		load(13'h1040, 8'h03, 1'b0);
		pin = 1'b0;
		repeat (4) @(negedge clock);
		`CHK(acc_level, 1'b1)
		`CHK(second_bit, 1'b1)
		foreach (addrs[i]) rd(1'b1, 1'b0, 1'b0, addrs[i]);
		repeat (2) @(negedge clock);
		`CHK(fq.size() + vq.size(), 0)
		$display("second bit done");
		summarize();
	end
endmodule : tb_rom_code_security_encryption
